//--- logic/maint_pkg.sv
package maint_pkg;

    // Control-out code {select, master, sync} that calls up maintenance
    localparam logic [2:0] MAINT_CODE      = 3'h1;

    // Outbound triplicated copies on the driven bus
    localparam int         DATA_OUT_B2     = 7;
    localparam int         DATA_OUT_B1     = 4;
    localparam int         DATA_OUT_B0     = 1;
    localparam int         ENABLE_OUT_B2   = 6;
    localparam int         ENABLE_OUT_B1   = 3;
    localparam int         ENABLE_OUT_B0   = 0;
    localparam int         CLOCK_OUT_B1    = 5;
    localparam int         CLOCK_OUT_B0    = 2;
    localparam int         CLOCK_OUT_PAR   = 8;

    // Position of the control-out lines inside the sampled pin vector
    localparam int         PIN_SYNC        = 9;
    localparam int         PIN_MASTER      = 10;
    localparam int         PIN_SELECT      = 11;
    localparam int         PIN_WIDTH       = 12;

    // Inbound triplicated copies on the returned bus
    localparam int         DATA_IN_B2      = 7;
    localparam int         DATA_IN_B1      = 4;
    localparam int         DATA_IN_B0      = 1;
    localparam int         CLOCK_IN_B2     = 6;
    localparam int         CLOCK_IN_B1     = 3;
    localparam int         CLOCK_IN_B0     = 0;
    localparam int         RESPONSE_IN_B1  = 5;
    localparam int         RESPONSE_IN_B0  = 2;

    localparam int         WRITE_BITS      = 4;
    localparam logic [7:0] BUS_B_RESET     = 8'h00;
    localparam logic [7:0] BUS_B_OE_RESET  = 8'hFF;
    localparam logic [2:0] ORDER_RESET     = 3'h0;
    localparam logic [3:0] SHIFT_RESET     = 4'h0;
    // System cycles by which the link-side reset request outlasts reset
    localparam logic [3:0] LINK_RESET_HOLD = 4'hF;

endpackage : maint_pkg

//--- logic/maint_slave.sv
`timescale 1ns/1ps

// Operation
// (R1) Master calls maintenance by driving select low, master low, sync high.
// (R2) While maintenance is seen, all interface drivers are released.
// (R3) Mode 1: data majority at sync fall resets slave and keeps drivers released.
// (R4) Mode 1 reset lasts while voted data stays active.
// (R5) Mode 1: no data majority at sync fall restores drivers, no reset.
// (R6) Master raises data and enable before sync drops to catch mode 2 slaves.
// (R7) Drivers released by mode 1 return at the selective-reset first state.
// (R8) Mode 2 address match during maintenance selects slave and re-enables drivers.
// (R9) Mode 2 reset and release need both data and enable at sync fall.
// (R10) Mode 2 reset ends when data or enable drops.
// (R11) Mode 2 drivers return by selective reset or new maintenance selection.
// (R12) Every maintenance signal is a majority of three lines; select, master and sync are single lines compared directly, not voted.
// (R13) Falling enable ends a write; the shifted bits are then examined.
// (R14) Voted clock-out is the serial shift strobe in both directions.
// (R15) Enable, clock and data together fix the next transfer direction.
// (R16) Data on driven bus bits 7,4,1; enable on 6,3,0.
// (R17) Clock-out on driven bus bits 5, 2 and parity.
// (R18) Returned data on 7,4,1; clock-in 6,3,0; response 5,2 and parity.
// (R19) Data sampled by clock before enable rises: active write, else read.
// (R20) Last bit before enable drops: set means address, clear means order.
// (R21) New selection raises response until clock-out rises or sync drops.
// (R22) Votes are taken on steady levels, never on edges.
// (R23) Voted signals are synchronised; sync fall decided in one clean cycle.
module maint_slave
    import maint_pkg::*;
#(
    parameter int MM2_CAPABLE = 1
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       link_clk,
    input  wire logic       select_out,
    input  wire logic       master_out,
    input  wire logic       sync_out,
    input  wire logic [7:0] bus_a,
    input  wire logic       bus_a_parity,
    input  wire logic       resetsel1,
    input  wire logic [2:0] own_address,
    input  wire logic       fault_data,
    output logic            drivers_released,
    output logic            slave_reset,
    output logic            order_strobe,
    output logic [2:0]      order_code,
    output logic [7:0]      bus_b_out,
    output logic [7:0]      bus_b_oe_n,
    output logic            bus_b_parity_out,
    output logic            bus_b_parity_oe_n
);

    if (MM2_CAPABLE < 0 || MM2_CAPABLE > 1) begin : g_bad_mode
        $error("MM2_CAPABLE must be 0 or 1");
    end

    function automatic logic vote(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction : vote

    // Reset stretched so the slower link clock cannot miss a short pulse
    logic [3:0] rst_count;
    logic       link_rst_req;

    always_ff @(posedge clk) begin
        if (reset) begin
            rst_count    <= LINK_RESET_HOLD;
            link_rst_req <= 1'b1;
        end else begin
            rst_count    <= (rst_count == 4'h0) ? 4'h0 : rst_count - 4'h1;
            link_rst_req <= (rst_count != 4'h0);
        end
    end

    // Link domain: reset and slow side inputs brought over
    logic                 lrst_s1;
    logic                 link_reset;
    logic [4:0]           side_s1;
    logic [4:0]           side_s2;
    logic [PIN_WIDTH-1:0] pin_s1;
    logic [PIN_WIDTH-1:0] pin_s2;

    always_ff @(posedge link_clk) begin
        lrst_s1    <= link_rst_req;
        link_reset <= lrst_s1;
        side_s1    <= {resetsel1, fault_data, own_address};
        side_s2    <= side_s1;
        pin_s1     <= {select_out, master_out, sync_out, bus_a_parity, bus_a};
        pin_s2     <= pin_s1;
    end

    wire logic [2:0] addr_s      = side_s2[2:0];
    wire logic       fault_s     = side_s2[3];
    wire logic       resetsel1_s = side_s2[4];

    // Majority of the steady synchronised levels; the maintenance code is compared directly
    wire logic data_v  = vote(pin_s2[DATA_OUT_B2], pin_s2[DATA_OUT_B1], pin_s2[DATA_OUT_B0]);  // R12 R16 R22
    wire logic ena_v   = vote(pin_s2[ENABLE_OUT_B2], pin_s2[ENABLE_OUT_B1], pin_s2[ENABLE_OUT_B0]);  // R12 R16
    wire logic clk_v   = vote(pin_s2[CLOCK_OUT_B1], pin_s2[CLOCK_OUT_B0], pin_s2[CLOCK_OUT_PAR]);  // R12 R17
    wire logic maint_v = ({pin_s2[PIN_SELECT], pin_s2[PIN_MASTER], pin_s2[PIN_SYNC]} == MAINT_CODE);  // R1

    logic       maint_d;
    logic       clk_d;
    logic       ena_d;
    logic [3:0] shift;
    logic       write_dir;
    logic       selected;
    logic       response;
    logic       mm_reset;
    logic       hold_release;
    logic       released_l;
    logic [2:0] order_l;
    logic       order_tog;

    wire logic       mm2        = (MM2_CAPABLE == 1);
    wire logic       sync_fall  = maint_d & ~pin_s2[PIN_SYNC];  // R23
    wire logic       reset_cond = mm2 ? (data_v & ena_v) : data_v;  // R3 R9
    wire logic       clk_rise   = clk_v & ~clk_d;  // R14
    wire logic       ena_fall   = ena_d & ~ena_v;  // R13
    wire logic       write_end  = ena_fall & write_dir & maint_d & mm2;  // R13
    wire logic [2:0] shift_addr = {shift[1], shift[2], shift[3]};  // R20
    wire logic       addr_hit   = write_end & shift[0] & (shift_addr == addr_s);  // R8 R20
    wire logic       addr_miss  = write_end & shift[0] & (shift_addr != addr_s);
    wire logic       order_hit  = write_end & ~shift[0] & selected;  // R20
    wire logic       read_clk   = selected & maint_d & ~write_dir & ena_v & clk_v;  // R14 R15

    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            maint_d <= 1'b0;
            clk_d   <= 1'b0;
            ena_d   <= 1'b0;
        end else begin
            maint_d <= maint_v;
            clk_d   <= clk_v;
            ena_d   <= ena_v;
        end
    end

    // Serial write capture and direction strobe
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            shift     <= SHIFT_RESET;
            write_dir <= 1'b0;
        end else begin
            if (clk_rise && ena_v) begin
                shift <= {shift[2:0], data_v};  // R14
            end
            if (clk_rise && !ena_v) begin
                write_dir <= data_v;  // R15 R19
            end
        end
    end

    // Selection, response and orders
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            selected  <= 1'b0;
            response  <= 1'b0;
            order_l   <= ORDER_RESET;
            order_tog <= 1'b0;
        end else begin
            if (!maint_v) begin
                selected <= 1'b0;
            end else if (addr_hit) begin
                selected <= 1'b1;  // R8
            end else if (addr_miss) begin
                selected <= 1'b0;
            end
            if (addr_hit) begin
                response <= 1'b1;  // R21
            end else if (clk_v || !maint_v) begin
                response <= 1'b0;  // R21
            end
            if (order_hit) begin
                order_l   <= shift_addr;  // R13
                order_tog <= ~order_tog;
            end
        end
    end

    // Reset and driver release decision
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            mm_reset     <= 1'b0;
            hold_release <= 1'b0;
            released_l   <= 1'b0;
        end else begin
            if (sync_fall && reset_cond) begin
                mm_reset <= 1'b1;  // R3 R9
            end else if (!reset_cond) begin
                mm_reset <= 1'b0;  // R4 R10
            end
            if (sync_fall) begin
                hold_release <= reset_cond;  // R3 R5 R9 R11
            end else if (resetsel1_s) begin
                hold_release <= 1'b0;  // R7 R11
            end
            released_l <= maint_d ? ~selected : hold_release;  // R2 R8
        end
    end

    // Returned signals, driven only by a selected slave
    logic [2:0] trio;

    always_comb begin
        trio = {fault_s, read_clk, response};
    end

    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            bus_b_out         <= BUS_B_RESET;
            bus_b_oe_n        <= BUS_B_OE_RESET;
            bus_b_parity_out  <= 1'b0;
            bus_b_parity_oe_n <= 1'b1;
        end else begin
            bus_b_out[DATA_IN_B2]     <= trio[2];  // R18
            bus_b_out[DATA_IN_B1]     <= trio[2];
            bus_b_out[DATA_IN_B0]     <= trio[2];
            bus_b_out[CLOCK_IN_B2]    <= trio[1];
            bus_b_out[CLOCK_IN_B1]    <= trio[1];
            bus_b_out[CLOCK_IN_B0]    <= trio[1];
            bus_b_out[RESPONSE_IN_B1] <= trio[0];
            bus_b_out[RESPONSE_IN_B0] <= trio[0];
            bus_b_parity_out          <= trio[0];
            bus_b_oe_n                <= {8{~(selected & maint_d)}};
            bus_b_parity_oe_n         <= ~(selected & maint_d);
        end
    end

    // System domain: levels and order event brought over
    logic [2:0] cross_s1;
    logic [2:0] cross_s2;
    logic       tog_d;

    always_ff @(posedge clk) begin
        cross_s1 <= {order_tog, mm_reset, released_l};
        cross_s2 <= cross_s1;
    end

    wire logic order_event = cross_s2[2] ^ tog_d;

    always_ff @(posedge clk) begin
        if (reset || link_rst_req) begin
            tog_d            <= 1'b0;
            drivers_released <= 1'b0;
            slave_reset      <= 1'b0;
            order_strobe     <= 1'b0;
            order_code       <= ORDER_RESET;
        end else begin
            tog_d            <= cross_s2[2];
            drivers_released <= cross_s2[0];  // R2
            slave_reset      <= cross_s2[1];  // R4
            order_strobe     <= order_event;
            if (order_event) begin
                order_code <= order_l;  // R13
            end
        end
    end

    // Checks
    sequence s_write_hit;
        addr_hit ##1 maint_d;
    endsequence

    sequence s_release_then_resetsel;
        hold_release && !maint_d && !sync_fall && resetsel1_s;
    endsequence

    AST_MAINT_RELEASE: assert property (@(posedge link_clk) disable iff (link_reset)  // R2
        maint_d && !selected |=> released_l)
        else $error("drivers not released in maintenance");
    AST_RESET_START: assert property (@(posedge link_clk) disable iff (link_reset)  // R3
        sync_fall && reset_cond |=> mm_reset && hold_release ##1 released_l || maint_d)
        else $error("reset or release missing after sync fall");
    AST_RESET_END: assert property (@(posedge link_clk) disable iff (link_reset)  // R10
        mm_reset && !reset_cond |=> !mm_reset)
        else $error("reset outlived its data or enable");
    AST_NO_RESET: assert property (@(posedge link_clk) disable iff (link_reset)  // R5
        sync_fall && !reset_cond |=> !mm_reset && !hold_release)
        else $error("reset raised without majority");
    AST_RESETSEL: assert property (@(posedge link_clk) disable iff (link_reset)  // R7
        s_release_then_resetsel |=> !hold_release ##1 (!released_l || maint_d || $past(maint_d)))
        else $error("drivers not restored at resetsel1");
    AST_SELECT: assert property (@(posedge link_clk) disable iff (link_reset)  // R8
        s_write_hit |-> selected && response ##1 (!released_l || !maint_d))
        else $error("address match did not select");
    AST_RESPONSE_DROP: assert property (@(posedge link_clk) disable iff (link_reset)  // R21
        response && !addr_hit && (clk_v || !maint_v) |=> !response)
        else $error("response held past clock or sync drop");
    AST_SHIFT: assert property (@(posedge link_clk) disable iff (link_reset)  // R14
        clk_rise && ena_v |=> shift[0] == $past(data_v) && shift[1] == $past(shift[0]))
        else $error("serial bit not shifted");
    AST_DIRECTION: assert property (@(posedge link_clk) disable iff (link_reset)  // R19
        clk_rise && !ena_v |=> write_dir == $past(data_v))
        else $error("transfer direction not taken");
    AST_ORDER: assert property (@(posedge link_clk) disable iff (link_reset)  // R20
        order_hit |=> order_tog != $past(order_tog) && order_l == $past(shift_addr))
        else $error("order not passed on");
    AST_RESPONSE_OUT: assert property (@(posedge link_clk) disable iff (link_reset)  // R18
        selected && maint_d |=> !bus_b_oe_n[RESPONSE_IN_B1] && bus_b_out[RESPONSE_IN_B1] == $past(response))
        else $error("response not driven");

endmodule : maint_slave

//--- verification/maint_master.sv
`timescale 1ns/1ps

module maint_master
    import maint_pkg::*;
(
    input  wire logic       clk,
    output logic            select_out,
    output logic            master_out,
    output logic            sync_out,
    output wire logic [7:0] bus_a,
    output wire logic       bus_a_parity
);
    logic       d;
    logic       e;
    logic       c;
    logic [1:0] bad;

    // A nonzero bad inverts one copy of every signal, like an open wire
    assign bus_a[DATA_OUT_B0]   = d ^ (bad == 2'h1);
    assign bus_a[DATA_OUT_B1]   = d ^ (bad == 2'h2);
    assign bus_a[DATA_OUT_B2]   = d ^ (bad == 2'h3);
    assign bus_a[ENABLE_OUT_B0] = e ^ (bad == 2'h1);
    assign bus_a[ENABLE_OUT_B1] = e ^ (bad == 2'h2);
    assign bus_a[ENABLE_OUT_B2] = e ^ (bad == 2'h3);
    assign bus_a[CLOCK_OUT_B0]  = c ^ (bad == 2'h1);
    assign bus_a[CLOCK_OUT_B1]  = c ^ (bad == 2'h2);
    assign bus_a_parity         = c ^ (bad == 2'h3);

    initial begin
        {select_out, master_out, sync_out} = 3'h0;
        d = 1'b0;
        e = 1'b0;
        c = 1'b0;
        bad = 2'h0;
    end

    // Every level is held long enough for both link synchroniser flops
    task automatic put(input logic [2:0] ctl, input logic nd, input logic ne, input logic nc);
        @(posedge clk);
        #1;
        {select_out, master_out, sync_out} = ctl;
        d = nd;
        e = ne;
        c = nc;
        repeat (12) @(posedge clk);
    endtask : put

    // Three value bits lsb first, then the flag bit
    task automatic write(input logic [2:0] val, input logic flag);
        logic [3:0] bits;
        bits = {flag, val};
        put(MAINT_CODE, 1'b1, 1'b0, 1'b1);
        put(MAINT_CODE, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            put(MAINT_CODE, bits[i], 1'b1, 1'b0);
            put(MAINT_CODE, bits[i], 1'b1, 1'b1);
        end
        put(MAINT_CODE, bits[3], 1'b1, 1'b0);
        put(MAINT_CODE, 1'b0, 1'b0, 1'b0);
    endtask : write
endmodule : maint_master

//--- verification/maint_slave_bench.sv
`timescale 1ns/1ps

module maint_slave_bench;
    import maint_pkg::*;
    logic       clk;
    logic       reset;
    logic       link_clk;
    logic       select_out;
    logic       master_out;
    logic       sync_out;
    logic [7:0] bus_a;
    logic       bus_a_parity;
    logic       resetsel1;
    logic       drivers_released;
    logic       slave_reset;
    logic       order_strobe;
    logic [2:0] order_code;
    logic [7:0] bus_b_out;
    logic [7:0] bus_b_oe_n;
    logic       bus_b_parity_out;
    logic       bus_b_parity_oe_n;
    logic       drivers_released_mm1;
    logic       slave_reset_mm1;
    logic       fault_bit;
    logic [2:0] last_code;
    int         n_fail;
    int         compares;
    int         n_strobe;
    int         cycles;
    localparam logic [2:0] ADDR = 3'h5;

    maint_slave #(.MM2_CAPABLE(1)) DUT (
        .clk(clk), .reset(reset), .link_clk(link_clk), .select_out(select_out),
        .master_out(master_out), .sync_out(sync_out), .bus_a(bus_a), .bus_a_parity(bus_a_parity),
        .resetsel1(resetsel1), .own_address(ADDR), .fault_data(fault_bit),
        .drivers_released(drivers_released), .slave_reset(slave_reset), .order_strobe(order_strobe),
        .order_code(order_code), .bus_b_out(bus_b_out), .bus_b_oe_n(bus_b_oe_n),
        .bus_b_parity_out(bus_b_parity_out), .bus_b_parity_oe_n(bus_b_parity_oe_n)
    );

    // Mode 1 only slave on the same lines
    maint_slave #(.MM2_CAPABLE(0)) DUT_MM1 (
        .clk(clk), .reset(reset), .link_clk(link_clk), .select_out(select_out),
        .master_out(master_out), .sync_out(sync_out), .bus_a(bus_a), .bus_a_parity(bus_a_parity),
        .resetsel1(resetsel1), .own_address(ADDR), .fault_data(fault_bit),
        .drivers_released(drivers_released_mm1), .slave_reset(slave_reset_mm1), .order_strobe(),
        .order_code(), .bus_b_out(), .bus_b_oe_n(), .bus_b_parity_out(), .bus_b_parity_oe_n()
    );

    maint_master m (
        .clk(clk), .select_out(select_out), .master_out(master_out), .sync_out(sync_out),
        .bus_a(bus_a), .bus_a_parity(bus_a_parity)
    );

    always #5 clk = ~clk;

    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #16 link_clk = ~link_clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (order_strobe === 1'b1) begin
            n_strobe++;
            last_code <= order_code;
        end
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic settle();
        repeat (20) @(posedge clk);
    endtask : settle

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic t_reset_release();
        m.put(MAINT_CODE, 1'b0, 1'b0, 1'b0);
        settle();
        chk("released in maint", 8'h01, drivers_released);
        m.put(MAINT_CODE, 1'b1, 1'b1, 1'b0);
        m.put(3'h0, 1'b1, 1'b1, 1'b0);
        settle();
        chk("reset after sync fall", 8'h01, slave_reset);
        chk("held released", 8'h01, drivers_released);
        chk("mm1 reset after sync fall", 8'h01, slave_reset_mm1);
        m.put(3'h0, 1'b0, 1'b1, 1'b0);
        settle();
        chk("reset ends", 8'h00, slave_reset);
        chk("still released", 8'h01, drivers_released);
        chk("mm1 reset ends", 8'h00, slave_reset_mm1);
        chk("mm1 still released", 8'h01, drivers_released_mm1);
        @(posedge clk) #1 resetsel1 = 1'b1;
        settle();
        chk("restored by resetsel1", 8'h00, drivers_released);
        chk("mm1 restored by resetsel1", 8'h00, drivers_released_mm1);
        @(posedge clk) #1 resetsel1 = 1'b0;
        $display("test reset_release done");
    endtask : t_reset_release

    task automatic t_no_reset();
        m.put(MAINT_CODE, 1'b1, 1'b0, 1'b0);
        m.put(3'h0, 1'b1, 1'b0, 1'b0);
        settle();
        chk("no reset data only", 8'h00, slave_reset);
        chk("restored", 8'h00, drivers_released);
        chk("mm1 reset data only", 8'h01, slave_reset_mm1);
        chk("mm1 released data only", 8'h01, drivers_released_mm1);
        m.put(3'h0, 1'b0, 1'b0, 1'b0);
        settle();
        chk("mm1 reset drops with data", 8'h00, slave_reset_mm1);
        $display("test no_reset done");
    endtask : t_no_reset

    task automatic t_select_order();
        m.bad = 2'h2;
        m.put(MAINT_CODE, 1'b0, 1'b0, 1'b0);
        m.write(ADDR, 1'b1);
        settle();
        chk("response oe", 8'h00, bus_b_oe_n[RESPONSE_IN_B1]);
        chk("response lines", 8'h07, {bus_b_parity_out, bus_b_out[RESPONSE_IN_B1], bus_b_out[RESPONSE_IN_B0]});
        chk("selected drivers", 8'h00, drivers_released);
        @(posedge clk) #1 fault_bit = 1'b1;
        m.put(MAINT_CODE, 1'b0, 1'b0, 1'b1);
        m.put(MAINT_CODE, 1'b0, 1'b0, 1'b0);
        m.put(MAINT_CODE, 1'b0, 1'b1, 1'b0);
        m.put(MAINT_CODE, 1'b0, 1'b1, 1'b1);
        chk("read lines", 8'hDB, bus_b_out);
        chk("parity oe", 8'h00, bus_b_parity_oe_n);
        m.put(MAINT_CODE, 1'b0, 1'b0, 1'b0);
        m.write(3'h6, 1'b0);
        settle();
        chk("order count", 8'h01, n_strobe[7:0]);
        chk("order code", 8'h06, last_code);
        chk("response dropped", 8'h00, bus_b_out[RESPONSE_IN_B1]);
        m.write(3'h2, 1'b1);
        settle();
        chk("deselected oe", 8'hFF, bus_b_oe_n);
        m.put(3'h0, 1'b0, 1'b0, 1'b0);
        m.bad = 2'h0;
        settle();
        chk("restored on leaving", 8'h00, drivers_released);
        chk("mm1 restored without data", 8'h00, drivers_released_mm1);
        $display("test select_order done");
    endtask : t_select_order

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        resetsel1 = 1'b0;
        fault_bit = 1'b0;
        last_code = 3'h0;
        n_fail = 0;
        compares = 0;
        n_strobe = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        repeat (30) @(posedge clk);
        t_reset_release();
        t_no_reset();
        t_select_order();
        conclude();
    end
endmodule : maint_slave_bench
